// File: pkg/lfp_pkg.sv
// shared constants and types of the frame buffer pixel formatter
`default_nettype none
package lfp_pkg;
  // pixel depth selection codes
  typedef enum logic [2:0]
  {
    LFP_BPP1,
    LFP_BPP2,
    LFP_BPP4,
    LFP_BPP8,
    LFP_BPP16,
    LFP_BPP24
  } lfp_bpp_type;

  // frame geometry
  localparam int MAX_FRAME_DIM = 2048;
  localparam int FRAME_CNT_W   = 23;
  // memory words and bit accumulator
  localparam int WORD_W        = 32;
  localparam int ACC_W         = 64;
  localparam int ACC_CNT_W     = 7;
  // fifo defaults
  localparam int FIFO_DEPTH    = 16;
  // palette geometry
  localparam int PAL_ENTRIES   = 256;
  localparam int PAL_IDX_W     = 8;
  localparam int PAL_W         = 16;
  // five-bit field layout shared by palette entries and 16 bpp words
  localparam int F5_BLUE_LSB   = 10;
  localparam int F5_GREEN_LSB  = 5;
  localparam int F5_RED_LSB    = 0;
  localparam int F5_W          = 5;
  // byte layout of 24 bpp pixels
  localparam int B8_BLUE_LSB   = 16;
  localparam int B8_GREEN_LSB  = 8;
  localparam int B8_RED_LSB    = 0;
  localparam int COMP_W        = 8;
  localparam logic [2:0] F5_PAD = 3'h0;
  // pixel widths in bits for each depth code
  localparam logic [6:0] BW_1  = 7'h01;
  localparam logic [6:0] BW_2  = 7'h02;
  localparam logic [6:0] BW_4  = 7'h04;
  localparam logic [6:0] BW_8  = 7'h08;
  localparam logic [6:0] BW_16 = 7'h10;
  localparam logic [6:0] BW_24 = 7'h18;
  // room needed in the accumulator to take a new word
  localparam logic [6:0] ACC_ROOM = 7'h20;
endpackage
`default_nettype wire

// File: rtl/lfp_formatter.sv
// frame buffer word fifo and pixel formatter toward the panel
//
// Operation
// - drives passive or active panels, frames up to 2048 by 2048 pixels.
// - plain frame buffer only; no character or drawing hardware.
// - drive polarity alternates every frame, no steady DC on cells.
// - pixel depths 1, 2, 4, 8, 16 and 24 bits selectable.
// - pixels tightly packed in memory, no padding, straddling words allowed.
// - depths up to eight bits index a palette of 16-bit entries.
// - entry holds blue 14..10, green 9..5, red 4..0, top five bits each.
// - expanded five-bit components get their three low bits zero.
// - 16 bpp words bypass palette, same five-bit field layout.
// - 24 bpp pixel: blue 23..16, green 15..8, red 7..0.
// - narrower panels receive only the most significant component bits.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo with registered status
module lfp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // elaboration check: pointer wrap logic needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin
    $error("lfp_fifo depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      wptr_nxt;
  logic [AW:0]      rptr_r;
  logic [AW:0]      rptr_nxt;
  logic             ready_r;
  logic             ready_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = ready_r;
  assign out_valid = (wptr_r != rptr_r);
  assign out_data  = mem[rptr_r[AW-1:0]];

  // pointer arithmetic; ready is registered so the port comes from a flop
  always_comb
  begin
    push      = in_valid && ready_r;
    pop       = out_ready && out_valid;
    wptr_nxt  = push ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt  = pop ? rptr_r + 1'b1 : rptr_r;
    ready_nxt = (wptr_nxt[AW-1:0] != rptr_nxt[AW-1:0]) || (wptr_nxt[AW] == rptr_nxt[AW]);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      wptr_r  <= wptr_nxt;
      rptr_r  <= rptr_nxt;
      ready_r <= ready_nxt;
    end
  end

  // storage has no reset; only entries between the pointers are ever read
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wptr_r[AW-1:0]] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// pixel unpacker, palette and colour formatter
module lfp_formatter #(
  parameter int PANEL_BITS = 8,
  parameter int FIFO_DEPTH = lfp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               rst,
  // configuration
  input  wire logic                               display_enable,
  input  wire logic [2:0]                         bpp_sel,
  input  wire logic [lfp_pkg::FRAME_CNT_W-1:0]    frame_pixels,
  // palette write port
  input  wire logic                               pal_we,
  input  wire logic [lfp_pkg::PAL_IDX_W-1:0]      pal_addr,
  input  wire logic [lfp_pkg::PAL_W-1:0]          pal_data,
  // frame buffer words from memory
  input  wire logic                               mem_valid,
  output logic                                    mem_ready,
  input  wire logic [lfp_pkg::WORD_W-1:0]         mem_data,
  // pixel stream toward the panel timing
  output logic                                    pix_valid,
  input  wire logic                               pix_ready,
  output logic      [PANEL_BITS-1:0]              pix_red,
  output logic      [PANEL_BITS-1:0]              pix_green,
  output logic      [PANEL_BITS-1:0]              pix_blue,
  output logic                                    frame_end,
  output logic                                    ac_polarity
);
  // elaboration check: component slices cannot exceed eight bits
  if (PANEL_BITS < 1 || PANEL_BITS > lfp_pkg::COMP_W)
  begin
    $error("lfp_formatter panel bits must lie in 1..8");
  end

  logic                          fifo_valid;
  logic                          fifo_pop;
  logic [lfp_pkg::WORD_W-1:0]    fifo_data;

  // word buffer between memory and the unpacker
  lfp_fifo #(
    .WIDTH (lfp_pkg::WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (mem_valid),
    .in_ready  (mem_ready),
    .in_data   (mem_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // palette store, written by software through the write port
  logic [lfp_pkg::PAL_W-1:0] palette [lfp_pkg::PAL_ENTRIES];

  always_ff @(posedge sys_clk)
  begin
    if (pal_we)
      palette[pal_addr] <= pal_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [lfp_pkg::ACC_W-1:0]       acc_r;
  logic [lfp_pkg::ACC_W-1:0]       acc_nxt;
  logic [lfp_pkg::ACC_CNT_W-1:0]   cnt_r;
  logic [lfp_pkg::ACC_CNT_W-1:0]   cnt_nxt;
  logic [lfp_pkg::FRAME_CNT_W-1:0] pix_cnt_r;
  logic [lfp_pkg::FRAME_CNT_W-1:0] pix_cnt_nxt;
  logic                            valid_r;
  logic                            valid_nxt;
  logic [PANEL_BITS-1:0]           red_r;
  logic [PANEL_BITS-1:0]           red_nxt;
  logic [PANEL_BITS-1:0]           green_r;
  logic [PANEL_BITS-1:0]           green_nxt;
  logic [PANEL_BITS-1:0]           blue_r;
  logic [PANEL_BITS-1:0]           blue_nxt;
  logic                            fend_r;
  logic                            fend_nxt;
  logic                            pol_r;
  logic                            pol_nxt;

  // working signals
  logic [6:0]                      bw;
  logic                            advance;
  logic                            issue;
  logic [lfp_pkg::ACC_W-1:0]       rem_acc;
  logic [lfp_pkg::ACC_CNT_W-1:0]   rem_cnt;
  logic [lfp_pkg::PAL_W-1:0]       entry;
  logic [lfp_pkg::COMP_W-1:0]      r8;
  logic [lfp_pkg::COMP_W-1:0]      g8;
  logic [lfp_pkg::COMP_W-1:0]      b8;
  logic [lfp_pkg::ACC_W-1:0]       pix_mask;

  assign pix_valid   = valid_r;
  assign pix_red     = red_r;
  assign pix_green   = green_r;
  assign pix_blue    = blue_r;
  assign frame_end   = fend_r;
  assign ac_polarity = pol_r;
  assign fifo_pop    = display_enable && fifo_valid && (rem_cnt <= lfp_pkg::ACC_ROOM);

  // pixel width from the depth code; unknown codes fall back to 1 bpp
  always_comb
  begin
    case (lfp_pkg::lfp_bpp_type'(bpp_sel))
      lfp_pkg::LFP_BPP1:  bw = lfp_pkg::BW_1;
      lfp_pkg::LFP_BPP2:  bw = lfp_pkg::BW_2;
      lfp_pkg::LFP_BPP4:  bw = lfp_pkg::BW_4;
      lfp_pkg::LFP_BPP8:  bw = lfp_pkg::BW_8;
      lfp_pkg::LFP_BPP16: bw = lfp_pkg::BW_16;
      lfp_pkg::LFP_BPP24: bw = lfp_pkg::BW_24;
      default:            bw = lfp_pkg::BW_1;
    endcase
  end

  // unpack, look up and format one pixel per accepted output slot
  always_comb
  begin
    advance  = !valid_r || pix_ready;
    issue    = display_enable && advance && (cnt_r >= bw);
    pix_mask = ~({lfp_pkg::ACC_W{1'b1}} << bw);
    // consumed pixel leaves from the low end, next sits lowest
    rem_acc  = issue ? (acc_r >> bw) : acc_r;
    rem_cnt  = issue ? cnt_r - bw : cnt_r;
    // new word lands right above the leftover bits, no gaps
    acc_nxt  = rem_acc | (fifo_pop ? ({{(lfp_pkg::ACC_W - lfp_pkg::WORD_W){1'b0}}, fifo_data} << rem_cnt) : '0);
    cnt_nxt  = fifo_pop ? rem_cnt + lfp_pkg::ACC_ROOM : rem_cnt;
    // palette index for depths up to eight, raw word at sixteen
    if (bw <= lfp_pkg::BW_8)
      entry = palette[acc_r[lfp_pkg::PAL_IDX_W-1:0] & pix_mask[lfp_pkg::PAL_IDX_W-1:0]];
    else
      entry = acc_r[lfp_pkg::PAL_W-1:0];
    if (bw == lfp_pkg::BW_24)
    begin
      b8 = acc_r[lfp_pkg::B8_BLUE_LSB +: lfp_pkg::COMP_W];
      g8 = acc_r[lfp_pkg::B8_GREEN_LSB +: lfp_pkg::COMP_W];
      r8 = acc_r[lfp_pkg::B8_RED_LSB +: lfp_pkg::COMP_W];
    end
    else
    begin
      b8 = {entry[lfp_pkg::F5_BLUE_LSB +: lfp_pkg::F5_W], lfp_pkg::F5_PAD};
      g8 = {entry[lfp_pkg::F5_GREEN_LSB +: lfp_pkg::F5_W], lfp_pkg::F5_PAD};
      r8 = {entry[lfp_pkg::F5_RED_LSB +: lfp_pkg::F5_W], lfp_pkg::F5_PAD};
    end
    valid_nxt   = advance ? issue : valid_r;
    red_nxt     = issue ? r8[lfp_pkg::COMP_W-1 -: PANEL_BITS] : red_r;
    green_nxt   = issue ? g8[lfp_pkg::COMP_W-1 -: PANEL_BITS] : green_r;
    blue_nxt    = issue ? b8[lfp_pkg::COMP_W-1 -: PANEL_BITS] : blue_r;
    // frame counter up to 2048 by 2048; polarity flips at each frame end
    fend_nxt    = issue && (pix_cnt_r + 1'b1 >= frame_pixels);
    pix_cnt_nxt = issue ? (fend_nxt ? '0 : pix_cnt_r + 1'b1) : pix_cnt_r;
    pol_nxt     = fend_nxt ? !pol_r : pol_r;
    // disabling drops partial words so the next frame starts clean
    if (!display_enable)
    begin
      acc_nxt     = '0;
      cnt_nxt     = '0;
      pix_cnt_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_r     <= '0;
      cnt_r     <= '0;
      pix_cnt_r <= '0;
      valid_r   <= 1'b0;
      red_r     <= '0;
      green_r   <= '0;
      blue_r    <= '0;
      fend_r    <= 1'b0;
      pol_r     <= 1'b0;
    end
    else
    begin
      acc_r     <= acc_nxt;
      cnt_r     <= cnt_nxt;
      pix_cnt_r <= pix_cnt_nxt;
      valid_r   <= valid_nxt;
      red_r     <= red_nxt;
      green_r   <= green_nxt;
      blue_r    <= blue_nxt;
      fend_r    <= fend_nxt;
      pol_r     <= pol_nxt;
    end
  end
endmodule
`default_nettype wire

// File: tb/lfp_formatter_asserts.sv
// concurrent checks on the pixel formatter ports
`default_nettype none
module lfp_formatter_asserts #(
  parameter int PANEL_BITS = 8
) (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // control and memory side
  input wire logic                  display_enable,
  input wire logic [2:0]            bpp_sel,
  input wire logic                  mem_valid,
  input wire logic                  mem_ready,
  // panel side
  input wire logic                  pix_valid,
  input wire logic                  pix_ready,
  input wire logic [PANEL_BITS-1:0] pix_red,
  input wire logic [PANEL_BITS-1:0] pix_green,
  input wire logic [PANEL_BITS-1:0] pix_blue,
  input wire logic                  frame_end,
  input wire logic                  ac_polarity
);
  // bits below the five kept ones; none when the panel is narrow
  localparam logic [PANEL_BITS-1:0] LOWM = (PANEL_BITS > 5) ? PANEL_BITS'((1 << (PANEL_BITS - 5)) - 1) : '0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // handshake steps on the pixel side
  sequence stall_s; pix_valid && !pix_ready; endsequence
  sequence take_s; pix_valid && pix_ready; endsequence
  pix_hold_a: assert property (stall_s |=> pix_valid && $stable({pix_red, pix_green, pix_blue}))
    else $error("pixel changed while stalled");
  idle_stop_a: assert property ((take_s ##0 !display_enable) |=> !pix_valid)
    else $error("pixel issued while disabled");
  idle_quiet_a: assert property (!display_enable && !pix_valid |=> !pix_valid)
    else $error("pixel appeared while disabled");
  pol_flip_a: assert property (frame_end |-> ac_polarity != $past(ac_polarity))
    else $error("polarity did not flip at frame end");
  pol_hold_a: assert property (!frame_end |-> $stable(ac_polarity))
    else $error("polarity moved inside a frame");
  fe_pix_a: assert property (frame_end |-> pix_valid)
    else $error("frame end without a pixel");
  low_zero_a: assert property (pix_valid && bpp_sel != 3'h5 |-> ((pix_red | pix_green | pix_blue) & LOWM) == '0)
    else $error("expanded component low bits set");
  fill_stop_a: assert property ($fell(mem_ready) |-> $past(mem_valid))
    else $error("fifo refused without a word taken");
endmodule
bind lfp_formatter lfp_formatter_asserts #(.PANEL_BITS(PANEL_BITS)) chk_u (.sys_clk(sys_clk), .rst(rst),
  .display_enable(display_enable), .bpp_sel(bpp_sel), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_red(pix_red), .pix_green(pix_green),
  .pix_blue(pix_blue), .frame_end(frame_end), .ac_polarity(ac_polarity));
`default_nettype wire

// File: tb/lfp_panel_model.sv
// panel model that takes pixels and logs them
`default_nettype none
module lfp_panel_model (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // panel supply and pacing
  input wire logic       supply_on,
  input wire logic       stall,
  // pixel stream
  input wire logic       pix_valid,
  output var logic       pix_ready,
  input wire logic [7:0] pix_red,
  input wire logic [7:0] pix_green,
  input wire logic [7:0] pix_blue
);
  logic        tog = 1'b0;
  logic [23:0] q[$];
  initial pix_ready = 1'b0;
  // stalling accepts every other cycle; no supply means no acceptance
  always @(negedge sys_clk)
  begin
    tog <= ~tog;
    pix_ready = supply_on && (!stall || tog);
  end
  // log top component bits as seen by the panel
  always @(posedge sys_clk)
    if (!rst && pix_valid && pix_ready)
      q.push_back({pix_blue, pix_green, pix_red});
endmodule
`default_nettype wire

// File: tb/lfp_formatter_test.sv
// self-checking bench for the pixel formatter
`default_nettype none
module lfp_formatter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rst = 1, display_enable = 0, pal_we = 0, mem_valid = 0, stall = 0, supply_on = 0;
  logic [2:0]  bpp_sel = 0;
  logic [22:0] frame_pixels = 0;
  logic [7:0]  pal_addr = 0;
  logic [15:0] pal_data = 0;
  logic [31:0] mem_data = 0;
  wire logic   mem_ready, pix_valid, pix_ready, frame_end, ac_polarity;
  wire logic [7:0] pix_red, pix_green, pix_blue;
  int          fails = 0, check_count = 0, cyc = 0, fe = 0;
  always #2 sys_clk = ~sys_clk;
  lfp_formatter dut_u (.sys_clk(sys_clk), .rst(rst), .display_enable(display_enable), .bpp_sel(bpp_sel),
    .frame_pixels(frame_pixels), .pal_we(pal_we), .pal_addr(pal_addr), .pal_data(pal_data), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_data(mem_data), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_red(pix_red),
    .pix_green(pix_green), .pix_blue(pix_blue), .frame_end(frame_end), .ac_polarity(ac_polarity));
  lfp_panel_model panel_u (.sys_clk(sys_clk), .rst(rst), .supply_on(supply_on), .stall(stall),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue));
  ////////////////////////////////////////////////////////////////////////////////
  // cycle count, frame count and hang limit
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (frame_end === 1'b1) fe <= fe + 1;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end
  function automatic logic [15:0] pv(input logic [7:0] i);
    return {1'b0, i[4:0], ~i[4:0], i[7:3]};
  endfunction
  // five-bit fields widened with zero low bits
  function automatic logic [23:0] ex5(input logic [15:0] e);
    return {e[14:10], 3'h0, e[9:5], 3'h0, e[4:0], 3'h0};
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // waits on the model's log; the hang limit bounds it
  task automatic getp(output logic [23:0] p);
    wait (panel_u.q.size() > 0);
    p = panel_u.q.pop_front();
  endtask
  // word held until a falling edge shows room; valid left up
  task automatic send(input logic [31:0] w);
    mem_valid = 1;
    mem_data = w;
    while (mem_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic start(input logic [2:0] b, input logic [22:0] n);
    @(negedge sys_clk) display_enable = 0;
    @(negedge sys_clk) bpp_sel = b;
    frame_pixels = n;
    panel_u.q.delete();
    @(negedge sys_clk) display_enable = 1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_index();
    logic [31:0] w;
    logic [23:0] p;
    int f0;
    logic pol0;
    w = 32'hC6A51E93;
    for (int k = 0; k < 4; k++)
    begin
      f0 = fe;
      pol0 = ac_polarity;
      start(3'(k), 23'(32 >> k));
      send(w);
      mem_valid = 0;
      for (int i = 0; i < (32 >> k); i++)
      begin
        getp(p);
        chk(p, ex5(pv(8'((w >> (i << k)) & ((1 << (1 << k)) - 1)))));
      end
      repeat (2) @(negedge sys_clk);
      chk(24'(fe - f0), 24'h000001);
      chk(24'(ac_polarity), 24'(!pol0));
    end
    $display("t_index done");
  endtask
  // unused depth code runs as 1 bpp; enable dropped mid-stream lets only the held pixel go
  task automatic t_halt();
    logic [31:0] w;
    logic [23:0] p;
    w = 32'hA5A5A5A6;
    start(3'h6, 23'd32);
    send(w);
    mem_valid = 0;
    getp(p);
    chk(p, ex5(pv(8'(w[0]))));
    @(negedge sys_clk) display_enable = 0;
    repeat (4) @(negedge sys_clk);
    chk(24'(panel_u.q.size()), 24'h000001);
    getp(p);
    chk(p, ex5(pv(8'(w[1]))));
    $display("t_halt done");
  endtask
  task automatic t_rgb16();
    logic [23:0] p;
    start(3'h4, 23'h000002);
    send(32'h7C1F03E0);
    mem_valid = 0;
    getp(p);
    chk(p, ex5(16'h03E0));
    getp(p);
    chk(p, ex5(16'h7C1F));
    $display("t_rgb16 done");
  endtask
  task automatic t_rgb24();
    logic [95:0] s;
    logic [23:0] p;
    s = {24'h3C4B5A, 24'h0F1E2D, 24'hABCDEF, 24'h123456};
    start(3'h5, 23'h000004);
    for (int i = 0; i < 3; i++) send(s[i*32+:32]);
    mem_valid = 0;
    for (int i = 0; i < 4; i++)
    begin
      getp(p);
      chk(p, s[i*24+:24]);
    end
    $display("t_rgb24 done");
  endtask
  // fill the fifo while disabled, then drain against a stalling panel
  task automatic t_fill();
    logic [23:0] p;
    int n;
    n = 0;
    @(negedge sys_clk) display_enable = 0;
    @(negedge sys_clk) bpp_sel = 3'h3;
    frame_pixels = 23'd64;
    panel_u.q.delete();
    mem_valid = 1;
    while (mem_ready === 1'b1 && n < 40)
    begin
      mem_data = n * 32'h04040404 + 32'h03020100;
      n++;
      @(negedge sys_clk);
    end
    mem_valid = 0;
    chk(24'(n), 24'(lfp_pkg::FIFO_DEPTH));
    stall = 1;
    display_enable = 1;
    for (int j = 0; j < 64; j++)
    begin
      getp(p);
      chk(p, ex5(pv(8'(j))));
    end
    stall = 0;
    $display("t_fill done");
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) rst = 0;
    @(negedge sys_clk);
    for (int i = 0; i < 256; i++)
    begin
      pal_we = 1;
      pal_addr = 8'(i);
      pal_data = pv(8'(i));
      @(negedge sys_clk);
    end
    pal_we = 0;
    supply_on = 1;
    t_index();
    t_halt();
    t_rgb16();
    t_rgb24();
    t_fill();
    supply_on = 0;
    close_out();
  end
endmodule
`default_nettype wire
